// file: verilog/bca_core.sv
// Capacity accounting core: counters, learning, empty thresholds, temperature code.
// Assumes count pulses and register writes come from sensing and serial logic outside.
`timescale 1ns/1ps
module bca_core
	import bca_pkg::*;
#(
	parameter int          SEC_CNT = SEC_CYCLES,  // Cycles per second, shorten for simulation
	parameter logic [15:0] PROGRAMMED_FULL_CAPACITY     = 16'haf00     // Programmed full capacity
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// Supply monitor
	input  wire logic        supply_ok,         // Supply above backup threshold
	// Sensing
	input  wire logic [11:0] battery_sense_mv,  // Scaled battery voltage
	input  wire logic [3:0]  temp_step,         // Internal temperature step 0..15, read back clamped to 12
	input  wire logic        charge_tick,       // One raw charge count
	input  wire logic        fast_charge,       // Charge rate at or above fast level
	input  wire logic        discharge_tick,    // One raw discharge count
	input  wire logic        selfdis_tick,      // Base self-discharge time tick
	input  wire logic        absolute_mode,     // Display reference select
	// Register access
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata_r,
	// Status
	output logic [15:0]      available_capacity_count_r,
	output logic [15:0]      discharge_counter_r,
	output logic [15:0]      learned_capacity_r,
	output logic [15:0]      full_reference_r,
	output logic             first_empty_flag_r,
	output logic             final_empty_flag_r
);
	typedef enum {ST_IDLE, ST_FULL, ST_EMPTY} bca_learn_t;

	logic [7:0]  offset_r, loadcomp_r, pincap_r, flags2_r;
	logic        pin_zero_r;      // Pin capacity zero written, awaiting learned zero
	logic        soft_rst;        // Serial reset sequence completed
	logic        sup_d_r;         // Previous supply state
	logic        corrupt;         // Shadow mismatch
	logic        reinit;          // Full reinitialisation request
	logic [7:0]  acc_r;           // Fractional accumulator for scaled counts
	logic [1:0]  upd_r;           // Consecutive charge updates
	logic        valid_chg;
	logic        partial_r;       // Partial charge during discharge
	bca_learn_t  learn_r;
	logic        inc, dec;
	logic [31:0] sec_r;
	logic [3:0]  secs1_r, secs2_r;
	logic [3:0]  need;
	logic [1:0]  tband;
	logic [11:0] final_mv;
	logic        overload_flag;

	assign overload_flag     = flags2_r[FLAGS2_OVERLOAD_FLAG];
	assign final_mv = FIRST_EMPTY_MV - FINAL_DROP_MV;
	assign soft_rst = reg_wr && reg_addr == ADDR_LEARNED && reg_wdata == 8'h00 && pin_zero_r;
	assign reinit   = soft_rst || (supply_ok && !sup_d_r && corrupt);

	// Shadow check of the learned capacity register
	bca_shadow #(.W(16)) u_shadow (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.wr      (1'b1),
		.din     (learned_capacity_r),
		.live    (learned_capacity_r),
		.mismatch_r (corrupt)
	);

	// Supply edge tracking
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			sup_d_r <= 1'b1; // Idle level, so reset alone gives no false supply rise
		else
			sup_d_r <= supply_ok;
	end

	// Serial register writes and reset sequence tracking
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			offset_r   <= 8'h00;
			loadcomp_r <= 8'h00;
			pincap_r   <= 8'h00;
			flags2_r   <= 8'h00;
			pin_zero_r <= 1'b0;
		end else if (reg_wr) begin
			// Any other write breaks the sequence
			pin_zero_r <= (reg_addr == ADDR_PINCAP) && (reg_wdata == 8'h00);
			if (reg_addr == ADDR_OFFSET)   offset_r   <= reg_wdata;
			if (reg_addr == ADDR_LOADCOMP) loadcomp_r <= reg_wdata;
			if (reg_addr == ADDR_PINCAP)   pincap_r   <= reg_wdata;
			if (reg_addr == ADDR_FLAGS2)   flags2_r   <= reg_wdata;
		end
	end

	// Register readback
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata_r <= 8'h00;
		else begin
			unique case (reg_addr)
				ADDR_LEARNED:  reg_rdata_r <= learned_capacity_r[15:8];
				ADDR_OFFSET:   reg_rdata_r <= offset_r;
				ADDR_LOADCOMP: reg_rdata_r <= loadcomp_r;
				ADDR_PINCAP:   reg_rdata_r <= pincap_r;
				ADDR_TEMP:     reg_rdata_r <= {(temp_step > TEMP_CODE_MAX) ? TEMP_CODE_MAX : temp_step, 4'h0};
				ADDR_FLAGS2:   reg_rdata_r <= flags2_r;
				default:       reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// Scaled count generation: weight added per raw tick, overflow yields one count
	// Charge weight from rate and temperature, discharge adds load and offset terms, self-discharge temperature and load terms.
	logic [8:0] add;
	always_comb begin
		add = 9'h000;
		if (charge_tick)
			add = 9'(8'hf0 - (fast_charge ? 8'h08 : 8'h20) - (temp_step > CODE_BELOW_30 ? 8'h10 : 8'h00));
		else if (discharge_tick)
			add = 9'(8'h80) + 9'(loadcomp_r >> 1) + 9'(offset_r >> 2);
		else if (selfdis_tick)
			add = 9'(temp_step << 4) + 9'(loadcomp_r >> 3);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			acc_r <= 8'h00;
		else
			acc_r <= 8'(9'(acc_r) + add);
	end
	// Ten bits so a heavy discharge weight cannot wrap the carry test
	assign inc = charge_tick && (10'(acc_r) + 10'(add) > 10'h0ff);
	// Charge has priority; a tick beside a charge tick is not a discharge step
	assign dec = !charge_tick && (discharge_tick || selfdis_tick) && (10'(acc_r) + 10'(add) > 10'h0ff);

	// Valid charge qualification
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			upd_r <= 2'h0;
		else if (discharge_tick)
			upd_r <= 2'h0;
		else if (inc && upd_r <= VALID_UPDATES)
			upd_r <= upd_r + 2'h1;
	end
	assign valid_chg = inc && (upd_r == VALID_UPDATES);

	// Reference for display
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			full_reference_r <= 16'h0000;
		else
			full_reference_r <= absolute_mode ? PROGRAMMED_FULL_CAPACITY : learned_capacity_r;
	end

	// Available capacity counter
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			available_capacity_count_r <= 16'h0000;
		else if (reinit)
			available_capacity_count_r <= 16'h0000;
		else if (inc && available_capacity_count_r < learned_capacity_r)
			available_capacity_count_r <= available_capacity_count_r + 16'h1;
		else if (dec && available_capacity_count_r != 16'h0000)
			available_capacity_count_r <= available_capacity_count_r - 16'h1;
	end

	// Discharge counter, cleared at full
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			discharge_counter_r <= 16'h0000;
		else if (reinit || available_capacity_count_r == learned_capacity_r)
			discharge_counter_r <= 16'h0000;
		else if (dec && discharge_counter_r != CNT_MAX &&
		         (discharge_tick || available_capacity_count_r != 16'h0000))
			discharge_counter_r <= discharge_counter_r + 16'h1;
	end

	// Learning cycle: full, then empty without partial charge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			learn_r   <= ST_IDLE;
			partial_r <= 1'b0;
		end else if (reinit) begin
			learn_r   <= ST_IDLE;
			partial_r <= 1'b0;
		end else begin
			unique case (learn_r)
				ST_IDLE:  if (available_capacity_count_r == learned_capacity_r) begin
					learn_r   <= ST_FULL;
					partial_r <= 1'b0;
				end
				ST_FULL: begin
					if (valid_chg && available_capacity_count_r != learned_capacity_r)
						partial_r <= 1'b1;
					if (first_empty_flag_r)
						learn_r <= ST_EMPTY;
				end
				ST_EMPTY: if (valid_chg)
					learn_r <= ST_IDLE;
			endcase
		end
	end

	// Learned capacity update with bounded decrease
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			learned_capacity_r <= PROGRAMMED_FULL_CAPACITY;
		else if (reinit)
			learned_capacity_r <= PROGRAMMED_FULL_CAPACITY;
		else if (learn_r == ST_EMPTY && valid_chg && !partial_r) begin
			if (discharge_counter_r < learned_capacity_r - (learned_capacity_r >> 2))
				learned_capacity_r <= learned_capacity_r - (learned_capacity_r >> 2);
			else
				learned_capacity_r <= discharge_counter_r;
		end
	end

	// Five times the count, wide enough that a large reference cannot wrap it
	logic [18:0] avail_x5;
	assign avail_x5 = 19'({available_capacity_count_r, 2'b00}) + 19'(available_capacity_count_r);

	// Delay selection by capacity and temperature band
	always_comb begin
		tband = (temp_step <= CODE_BELOW_10) ? 2'd0 : (temp_step <= CODE_BELOW_30) ? 2'd1 : 2'd2;
		if (avail_x5 > 19'({learned_capacity_r, 1'b0}))
			need = DLY_HI[tband];   // Above 40%
		else if (avail_x5 > 19'(learned_capacity_r))
			need = DLY_MID[tband];  // 20% to 40%
		else
			need = DLY_LO;          // Below 20%
	end

	// One-second time base
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			sec_r <= 32'h0;
		else
			sec_r <= (sec_r >= 32'(SEC_CNT - 1)) ? 32'h0 : sec_r + 32'h1;
	end

	// Low-voltage timers; recovery restarts, overload holds off
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			secs1_r <= 4'h0;
			secs2_r <= 4'h0;
		end else begin
			if (overload_flag || battery_sense_mv >= FIRST_EMPTY_MV)
				secs1_r <= 4'h0;
			else if (sec_r == 32'h0 && secs1_r != 4'hf)
				secs1_r <= secs1_r + 4'h1;
			if (overload_flag || battery_sense_mv >= final_mv)
				secs2_r <= 4'h0;
			else if (sec_r == 32'h0 && secs2_r != 4'hf)
				secs2_r <= secs2_r + 4'h1;
		end
	end

	// Latched empty flags, cleared only by valid charge or reinitialisation
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			first_empty_flag_r <= 1'b0;
			final_empty_flag_r <= 1'b0;
		end else begin
			if (!overload_flag && secs1_r >= need)
				first_empty_flag_r <= 1'b1;
			else if (valid_chg || reinit)
				first_empty_flag_r <= 1'b0;
			if (!overload_flag && secs2_r >= need)
				final_empty_flag_r <= 1'b1;
			else if (valid_chg || reinit)
				final_empty_flag_r <= 1'b0;
		end
	end

	// Checks
	cap_bound_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		available_capacity_count_r <= learned_capacity_r || $past(reinit) || $changed(learned_capacity_r))
		else $error("capacity above reference");
	dcr_sat_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$past(discharge_counter_r) == CNT_MAX |-> discharge_counter_r != 16'h0000 || $past(reinit)
		|| $past(available_capacity_count_r == learned_capacity_r))
		else $error("discharge counter wrapped");
	flag_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		first_empty_flag_r && !valid_chg && !reinit |=> first_empty_flag_r)
		else $error("empty flag dropped");
	overload_flag_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		overload_flag && !first_empty_flag_r |=> !first_empty_flag_r)
		else $error("flag set under overload");
	soft_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		soft_rst |=> learned_capacity_r == PROGRAMMED_FULL_CAPACITY && available_capacity_count_r == 16'h0000)
		else $error("serial reset missed");
	learn_drop_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!$past(reinit) |-> learned_capacity_r >= $past(learned_capacity_r) - ($past(learned_capacity_r) >> 2))
		else $error("learned capacity fell too far");
	ref_sel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		absolute_mode |=> full_reference_r == PROGRAMMED_FULL_CAPACITY)
		else $error("wrong display reference");
	timer_rst_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		battery_sense_mv >= FIRST_EMPTY_MV |=> secs1_r == 4'h0)
		else $error("timer not restarted");
	corrupt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		supply_ok && !sup_d_r && corrupt |=> available_capacity_count_r == 16'h0000)
		else $error("corruption not handled");
endmodule

// file: include/bca_pkg.sv
// Constants for the battery capacity accounting core.
// Assumes a single 25 MHz clock and an external serial engine that hands in register writes.
// Operation
// - Corrupt registers after dip force capacity reload
// - Two empty thresholds, final 100mV below first
// - Empty flags latch until next valid charge
// - Delay from capacity band and temperature band
// - Overload flag suspends empty threshold monitoring
// - Zero writes to 1eh then 05h reset
// - Temperature code in upper nibble, ten-degree bands
// - Temperature step selects charge and self-discharge
// - Charge counts scaled by rate and temperature
// - Discharge counts compensated by load register
// - Self-discharge compensated by load and temperature
// - Charge increments; discharge decrements, counts discharge
// - Available capacity corrected by offset register
// - Learn only after uninterrupted full-to-empty discharge
// - Learned capacity equals programmed capacity at init
// - Available capacity never exceeds reference on charge
// - Learned capacity drops at most 25 percent
// - Relative uses learned, absolute uses programmed reference
// - Valid charge needs more than two updates
// - Discharge counter saturates at maximum
package bca_pkg;
	localparam logic [7:0]  ADDR_LEARNED   = 8'h05;
	localparam logic [7:0]  ADDR_OFFSET    = 8'h0b;
	localparam logic [7:0]  ADDR_LOADCOMP  = 8'h0e;
	localparam logic [7:0]  ADDR_PINCAP    = 8'h1e;
	localparam logic [7:0]  ADDR_TEMP      = 8'h20;  // Chosen location for temperature code
	localparam logic [7:0]  ADDR_FLAGS2    = 8'h21;  // Chosen location for second flag register
	localparam int          FLAGS2_OVERLOAD_FLAG    = 0;      // Overload bit position
	localparam logic [11:0] FIRST_EMPTY_MV = 12'h3e8; // 1.00 V on battery sense
	localparam logic [11:0] FINAL_DROP_MV  = 12'h064; // 100 mV below first
	localparam int          CLK_HZ         = 25000000;
	localparam int          SEC_CYCLES     = CLK_HZ;  // One second
	localparam logic [15:0] CNT_MAX        = 16'hffff;
	localparam logic [1:0]  VALID_UPDATES  = 2'h2;    // Charge valid beyond this many updates
	localparam logic [3:0]  TEMP_CODE_MAX  = 4'hc;
	localparam logic [3:0]  CODE_BELOW_10  = 4'h4;    // Codes up to this are below 10 C
	localparam logic [3:0]  CODE_BELOW_30  = 4'h6;    // Codes up to this are below 30 C
	// Delay seconds per capacity band, indexed by temperature band cold/mid/warm; lowest band fixed
	localparam logic [3:0]  DLY_HI [3] = '{4'h7, 4'h6, 4'h5};
	localparam logic [3:0]  DLY_MID[3] = '{4'h4, 4'h3, 4'h2};
	localparam logic [3:0]  DLY_LO     = 4'h2;
endpackage

// file: verilog/bca_shadow.sv
// Shadow copy store used to detect register corruption.
// Assumes write and compare happen in the core clock domain.
`timescale 1ns/1ps
module bca_shadow #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// Store and compare
	input  wire logic         wr,
	input  wire logic [W-1:0] din,
	input  wire logic [W-1:0] live,
	output logic              mismatch_r
);
	logic [W-1:0] copy_r; // Inverted copy so stuck bits differ

	// Refresh inverted copy on every write
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			copy_r <= '1;
		else if (wr)
			copy_r <= ~din;
	end

	// Registered comparison, differing content flags loss
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			mismatch_r <= 1'b0;
		else
			mismatch_r <= (copy_r != ~live);
	end
endmodule

// file: bench/bca_host_model.sv
// Host processor model on the register link: register writes and read address selection.
// Assumes the core takes a write on the rising edge of ref_clk while reg_wr is high.
`timescale 1ns/1ps
module bca_host_model
	import bca_pkg::*;
(
	// Clock
	input  wire logic ref_clk,
	// Register link
	output logic       reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// Idle link at time zero
	initial begin
		reg_wr    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
	end
	// One write strobe; a released data line shows the inverse, never the old value
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// Reset order matters: pin capacity first, learned capacity second
	task automatic reset_seq();
		write_reg(ADDR_PINCAP, 8'h00);
		write_reg(ADDR_LEARNED, 8'h00);
	endtask
	// Select a read address; the answer stands one cycle later
	task automatic point(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
	endtask
endmodule

// file: bench/test_battery_capacity_accounting.sv
// Self-checking bench for the capacity accounting core, host model on the register link.
// Assumes a one-second base shortened to SEC cycles; all checks go through a note queue.
`timescale 1ns/1ps
module test_battery_capacity_accounting;
	import bca_pkg::*;
	localparam int          SEC  = 20;       // Short second for simulation
	localparam logic [15:0] FULL = 16'h0040; // Small programmed capacity, so a full charge fits the run
	typedef struct { int w; logic [15:0] e; } bca_note_t;
	logic             ref_clk = 1'b0;
	logic             arst_n  = 1'b0;
	logic             ch_t    = 1'b0;     // Charge pulse
	logic             dis_t   = 1'b0;     // Discharge pulse
	logic             sd_t    = 1'b0;     // Self-discharge pulse
	logic             fast    = 1'b0;
	logic             abs_m   = 1'b0;
	logic             sup     = 1'b1;     // Supply above backup threshold
	logic [3:0]       temp    = 4'h6;
	logic [11:0]      sense   = 12'h4b0;  // Well above both thresholds
	logic             reg_wr;
	logic [7:0]       reg_addr;
	logic [7:0]       reg_wdata;
	logic [7:0]       rdata;
	logic [15:0]      avail, dcnt, learn, fref;
	logic             f1, ff;
	logic [31:0]      seed    = 32'd81;   // Xorshift state
	bca_note_t        q[$];               // Expected results, oldest first
	int               fails = 0, check_count = 0;
	event             take;
	logic [7:0]       r8;
	// Clock
	always #20 ref_clk = ~ref_clk;
	// Register link partner
	bca_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	bca_core #(.SEC_CNT(SEC), .PROGRAMMED_FULL_CAPACITY(FULL)) DUT (
		.ref_clk(ref_clk), .arst_n(arst_n), .supply_ok(sup), .battery_sense_mv(sense), .temp_step(temp),
		.charge_tick(ch_t), .fast_charge(fast), .discharge_tick(dis_t), .selfdis_tick(sd_t),
		.absolute_mode(abs_m), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_r(rdata), .available_capacity_count_r(avail), .discharge_counter_r(dcnt),
		.learned_capacity_r(learn), .full_reference_r(fref), .first_empty_flag_r(f1), .final_empty_flag_r(ff));
	// Xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Report one mismatch
	task automatic miss(input string what, input logic [15:0] g, input logic [15:0] e);
		fails++;
		$display("Error at %0t: %s got %h expected %h", $time, what, g, e);
	endtask
	// Compare tasks, one per kind of result
	task automatic compare_word(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) miss("counter", g, e);
	endtask
	task automatic compare_flag(input logic [1:0] g, input logic [1:0] e);
		check_count++;
		if (g !== e) miss("flags", {14'h0, g}, {14'h0, e});
	endtask
	task automatic compare_byte(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) miss("register", {8'h0, g}, {8'h0, e});
	endtask
	// Watcher: takes the oldest note whenever a result is due
	always @(take) begin
		bca_note_t n;
		n = q.pop_front();
		case (n.w)
			0: compare_word(avail, n.e);
			1: compare_word(learn, n.e);
			2: compare_word(fref, n.e);
			3: compare_flag({f1, ff}, n.e[1:0]);
			4: compare_flag({1'b0, (avail != 16'h0) && (avail <= fref)}, n.e[1:0]);
			5: compare_flag({1'b0, dcnt != 16'h0}, n.e[1:0]);
			6: compare_byte({4'h0, rdata[7:4]}, n.e[7:0]);
			default: compare_byte(rdata, n.e[7:0]);
		endcase
	end
	// Note an expectation; the result is looked at once the edge's updates have landed
	task automatic expect_val(input int w, input logic [15:0] e);
		@(negedge ref_clk);
		q.push_back('{w, e});
		-> take;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Count pulses, one cycle high then one low; rate and self-discharge vary randomly
	task automatic pulses(input bit chg, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			ch_t  <= chg;
			dis_t <= !chg;
			fast  <= 1'(rnd());
			sd_t  <= 1'(rnd());
			@(posedge ref_clk);
			ch_t  <= 1'b0;
			dis_t <= 1'b0;
			sd_t  <= 1'b0;
		end
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#2000000;
		fails++;
		print_verdict();
	end
	// Main sequence
	initial begin
		cycles(2);
		arst_n <= 1'b1;
		cycles(2);
		expect_val(1, FULL);
		expect_val(0, 16'h0);
		expect_val(2, FULL);
		cycles(1);
		abs_m <= 1'b1;
		cycles(2);
		expect_val(2, FULL);
		$display("test reset values done");
		for (int s = 0; s < 16; s++) begin
			cycles(1);
			temp <= 4'(s);
			host.point(ADDR_TEMP);
			expect_val(6, (s > 12) ? 16'hc : 16'(s));
		end
		$display("test temperature code done");
		r8 = 8'(rnd());
		host.write_reg(ADDR_OFFSET, r8);
		host.point(ADDR_OFFSET);
		expect_val(7, {8'h0, r8});
		r8 = 8'(rnd());
		host.write_reg(ADDR_LOADCOMP, r8);
		host.write_reg(8'h3f, 8'h5a);
		host.point(ADDR_LOADCOMP);
		expect_val(7, {8'h0, r8});
		host.point(8'h3f);
		expect_val(7, 16'h0); // unmapped reads zero
		$display("test registers done");
		pulses(1, 600);
		expect_val(4, 16'h1);
		pulses(0, 600);
		expect_val(5, 16'h1);
		$display("test counting done");
		host.reset_seq();
		sense <= 12'h3b6;
		cycles(15);
		expect_val(3, 16'h0);
		cycles(80);
		expect_val(3, 16'h2);
		cycles(1);
		sense <= 12'h4b0;
		cycles(10);
		expect_val(3, 16'h2);
		host.write_reg(ADDR_PINCAP, 8'h00);
		host.write_reg(ADDR_OFFSET, 8'h00);
		host.write_reg(ADDR_LEARNED, 8'h00);
		cycles(2);
		expect_val(3, 16'h2);
		host.reset_seq();
		cycles(2);
		expect_val(3, 16'h0);
		expect_val(0, 16'h0);
		expect_val(1, FULL);
		$display("test empty flags and serial reset done");
		sense <= 12'h3b6;
		cycles(15);
		sense <= 12'h4b0;
		cycles(3);
		sense <= 12'h3b6;
		cycles(15);
		sense <= 12'h4b0;
		expect_val(3, 16'h0);
		host.write_reg(ADDR_FLAGS2, 8'h01);
		sense <= 12'h320;
		cycles(200);
		expect_val(3, 16'h0);
		$display("test timer restart and overload done");
		// Full battery, warm band: five seconds needed, the middle band would take two
		host.write_reg(ADDR_FLAGS2, 8'h00);
		sense <= 12'h4b0;
		pulses(1, 100);
		expect_val(0, FULL);
		cycles(1);
		sense <= 12'h3b6;
		cycles(70);
		expect_val(3, 16'h0);
		cycles(60);
		expect_val(3, 16'h2);
		// Short discharge after empty, then a valid charge: learned drops by a quarter
		cycles(1);
		sense <= 12'h4b0;
		pulses(0, 40);
		pulses(1, 10);
		expect_val(1, FULL - (FULL >> 2));
		expect_val(2, FULL);
		cycles(1);
		abs_m <= 1'b0;
		cycles(2);
		expect_val(2, FULL - (FULL >> 2));
		expect_val(3, 16'h0);
		$display("test capacity bands and learning done");
		// Supply dip with intact registers must not reload anything
		cycles(1);
		sup <= 1'b0;
		cycles(4);
		sup <= 1'b1;
		cycles(4);
		expect_val(1, FULL - (FULL >> 2));
		expect_val(4, 16'h1);
		$display("test supply dip done");
		print_verdict();
	end
endmodule
